// ==== logic/led_pwm_pkg.sv ====
package led_pwm_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] CTRL_OFS  = 8'h06;
   localparam logic [7:0] PWM_OFS   = 8'h16;
   localparam logic [7:0] CUR_OFS   = 8'h26;
   localparam logic [7:0] MISC_OFS  = 8'h36;
   localparam logic [7:0] HYST_OFS  = 8'h37;
   localparam logic [7:0] STAT_OFS  = 8'h38;
   localparam logic [7:0] FADER_OFS = 8'h48;
   // misc_config fields
   localparam int MISC_INTCLK_BIT = 0;
   localparam int MISC_PWMPS_BIT  = 2;
   localparam int MISC_MODE_LSB   = 3;
   localparam int MISC_PS_BIT     = 5;
   localparam int MISC_TC_BIT     = 6;
   // channel control fields
   localparam int CTRL_GRP_LSB = 0;
   localparam int CTRL_LOG_BIT = 5;
   // reset values
   localparam logic [7:0] HYST_DEF = 8'h10;
   // channel layout
   localparam int NCH                  = 9;
   localparam int NGRP                 = 3;
   localparam int boosted_output_first = 0;
   localparam int boosted_output_last  = 5;
   localparam int battery_output_first = 6;
   localparam int battery_output_last  = 8;
   localparam int NBOOST = boosted_output_last - boosted_output_first + 1;
   localparam int CUR_STEP_UA = 100;
   // timing
   localparam int CLK_HZ       = 200_000_000;
   localparam int PWM_HZ       = 312;
   localparam int PWM_STEPS    = 4096;
   localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
   localparam int IDLE_MS      = 50;
   localparam int IDLE_CYC     = (CLK_HZ / 1000) * IDLE_MS;
   localparam int FILT_US      = 20;
   localparam int FILT_CYC     = (CLK_HZ / 1_000_000) * FILT_US;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'b00,
      MODE_BYPASS = 2'b01,
      MODE_BOOST  = 2'b10,
      MODE_AUTO   = 2'b11
   } pump_mode_e;

   typedef enum logic [1:0] {
      GAIN_OFF  = 2'b00,
      GAIN_1X   = 2'b01,
      GAIN_1P5X = 2'b10,
      GAIN_WEAK = 2'b11
   } pump_gain_e;

   typedef struct packed {
      pump_gain_e gain;
      logic       discharge;
      logic       drivers_off;
      logic       analog_off;
      logic       wake_start;
   } power_ctrl_s;

   typedef struct packed {
      logic [7:0]                 misc;
      logic [7:0]                 hyst;
      logic [NCH-1:0][7:0]        ctrl;
      logic [NCH-1:0][7:0]        pwm;
      logic [NCH-1:0][7:0]        cur;
      logic [NGRP-1:0][7:0]       fader;
      logic [7:0]                 rdata;
      logic [7:0]                 pre;
      logic [11:0]                cnt;
      logic [NCH-1:0][11:0]       duty;
      logic [NCH-1:0]             led_on;
      logic [NBOOST-1:0]          sat_s1;
      logic [NBOOST-1:0]          sat_s2;
      logic                       bok_s1;
      logic                       bok_s2;
      logic [11:0]                filt;
      logic [15:0]                hcnt;
      logic [23:0]                idle;
      logic                       ps;
      power_ctrl_s                ctl;
   } led_state_s;
endpackage

// ==== logic/led_pwm_pump_ctrl.sv ====
`timescale 1ns/1ps
module led_pwm_pump_ctrl #(
   parameter int         PWM_STEP_CYC = led_pwm_pkg::PWM_STEP_CYC,
   parameter int         IDLE_CYC     = led_pwm_pkg::IDLE_CYC,
   parameter logic [7:0] HYST_DEF     = led_pwm_pkg::HYST_DEF
)(
   // clock and reset
   input  wire logic                                       ref_clk_in,
   input  wire logic                                       reset_n_in,
   // register port
   input  wire logic                                       reg_wr_in,
   input  wire logic [7:0]                                 reg_addr_in,
   input  wire logic [7:0]                                 reg_wdata_in,
   output logic [7:0]                                      reg_rdata_out,
   // program engines
   input  wire logic [led_pwm_pkg::NCH-1:0]                eng_own_in,
   input  wire logic [led_pwm_pkg::NCH-1:0][7:0]           eng_duty_in,
   input  wire logic                                       eng_gap_ahead_in,
   // analogue monitors, asynchronous
   input  wire logic [led_pwm_pkg::NBOOST-1:0]             boost_sat_in,
   input  wire logic                                       batt_ok_in,
   // analogue controls
   output logic [led_pwm_pkg::NCH-1:0]                     led_pwm_out,
   output logic [led_pwm_pkg::NCH-1:0][7:0]                led_current_out,
   output led_pwm_pkg::power_ctrl_s                        power_ctrl_out
);

   led_pwm_pkg::led_state_s s_r;
   led_pwm_pkg::led_state_s s_nxt;
   led_pwm_pkg::pump_mode_e pump_mode_sel;
   logic                    pwm_offtime_sleep_enable;
   logic                    active;
   logic                    idle_long;
   logic                    gain_up;
   logic                    gain_down;
   logic                    sat_any;
   logic [7:0]              src;
   logic [15:0]             prod;
   logic [11:0]             d12;
   logic [1:0]              grp;
   logic                    wrap;

   assign pump_mode_sel = led_pwm_pkg::pump_mode_e'(s_r.misc[led_pwm_pkg::MISC_MODE_LSB +: 2]);
   assign pwm_offtime_sleep_enable = s_r.misc[led_pwm_pkg::MISC_PWMPS_BIT];
   assign active    = |s_r.duty;
   assign idle_long = s_r.idle == 24'(IDLE_CYC);
   assign sat_any   = |s_r.sat_s2;
   assign gain_up   = s_r.filt == 12'(led_pwm_pkg::FILT_CYC);
   assign gain_down = s_r.hcnt >= {s_r.hyst, 8'h00};

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      src   = 8'h00;
      prod  = 16'h0000;
      d12   = 12'h000;
      grp   = 2'b00;
      wrap  = (s_r.pre == 8'(PWM_STEP_CYC - 1)) && (s_r.cnt == 12'hFFF);
      s_nxt = s_r;
      s_nxt.ctl.wake_start = 1'b0;
      s_nxt.sat_s1 = boost_sat_in;
      s_nxt.sat_s2 = s_r.sat_s1;
      s_nxt.bok_s1 = batt_ok_in;
      s_nxt.bok_s2 = s_r.bok_s1;

      // register writes
      if (reg_wr_in)
      begin
         if (reg_addr_in == led_pwm_pkg::MISC_OFS)
            s_nxt.misc = reg_wdata_in;
         if (reg_addr_in == led_pwm_pkg::HYST_OFS)
            s_nxt.hyst = reg_wdata_in;
         for (int i = 0; i < led_pwm_pkg::NCH; i++)
         begin
            if (reg_addr_in == led_pwm_pkg::CTRL_OFS + 8'(i))
               s_nxt.ctrl[i] = reg_wdata_in;
            if (reg_addr_in == led_pwm_pkg::PWM_OFS + 8'(i))
               s_nxt.pwm[i] = reg_wdata_in;
            if (reg_addr_in == led_pwm_pkg::CUR_OFS + 8'(i))
               s_nxt.cur[i] = reg_wdata_in;
         end
         for (int g = 0; g < led_pwm_pkg::NGRP; g++)
         begin
            if (reg_addr_in == led_pwm_pkg::FADER_OFS + 8'(g))
               s_nxt.fader[g] = reg_wdata_in;
         end
      end

      // reads answer one edge after the address is presented
      s_nxt.rdata = 8'h00;
      if (reg_addr_in == led_pwm_pkg::MISC_OFS)
         s_nxt.rdata = s_r.misc;
      if (reg_addr_in == led_pwm_pkg::HYST_OFS)
         s_nxt.rdata = s_r.hyst;
      if (reg_addr_in == led_pwm_pkg::STAT_OFS)
         s_nxt.rdata = {2'b00, sat_any, s_r.bok_s2, active, s_r.ps, s_r.ctl.gain};
      for (int i = 0; i < led_pwm_pkg::NCH; i++)
      begin
         if (reg_addr_in == led_pwm_pkg::CTRL_OFS + 8'(i))
            s_nxt.rdata = s_r.ctrl[i];
         if (reg_addr_in == led_pwm_pkg::PWM_OFS + 8'(i))
            s_nxt.rdata = s_r.pwm[i];
         if (reg_addr_in == led_pwm_pkg::CUR_OFS + 8'(i))
            s_nxt.rdata = s_r.cur[i];
      end
      for (int g = 0; g < led_pwm_pkg::NGRP; g++)
      begin
         if (reg_addr_in == led_pwm_pkg::FADER_OFS + 8'(g))
            s_nxt.rdata = s_r.fader[g];
      end

      // timebase runs free, power save included, so engine timing never slips
      if (s_r.pre == 8'(PWM_STEP_CYC - 1))
      begin
         s_nxt.pre = 8'h00;
         s_nxt.cnt = s_r.cnt + 12'h001;
      end
      else
         s_nxt.pre = s_r.pre + 8'h01;

      // per channel duty; new duty is taken only at period start to avoid runt pulses
      for (int i = 0; i < led_pwm_pkg::NCH; i++)
      begin
         src = eng_own_in[i] ? eng_duty_in[i] : s_r.pwm[i];
         grp = s_r.ctrl[i][led_pwm_pkg::CTRL_GRP_LSB +: 2];
         if (grp != 2'b00)
         begin
            prod = src * s_r.fader[grp - 2'b01];
            src  = 8'(prod / 16'h00FF);
         end
         if (!s_r.ctrl[i][led_pwm_pkg::CTRL_LOG_BIT])
            d12 = {src, src[7:4]};
         else if (src == 8'h00)
            d12 = 12'h000;
         else
            d12 = {1'b1, src[4:0], 6'h00} >> (3'h7 - src[7:5]);
         if (s_r.misc[led_pwm_pkg::MISC_TC_BIT])
            d12 = d12 >> 1;
         if (wrap)
            s_nxt.duty[i] = d12;
         s_nxt.led_on[i] = (s_r.cnt < s_r.duty[i]) && !s_r.ps;
      end

      // inactivity timer
      if (active)
         s_nxt.idle = 24'h000000;
      else if (!idle_long)
         s_nxt.idle = s_r.idle + 24'h000001;

      // saturation filter, a transient shorter than the filter is ignored
      if (!sat_any)
         s_nxt.filt = 12'h000;
      else if (!gain_up)
         s_nxt.filt = s_r.filt + 12'h001;
      if (!s_r.bok_s2 || sat_any)
         s_nxt.hcnt = 16'h0000;
      else if (!gain_down)
         s_nxt.hcnt = s_r.hcnt + 16'h0001;

      // automatic power save
      if (s_r.ps)
      begin
         if (active || !s_r.misc[led_pwm_pkg::MISC_PS_BIT])
         begin
            s_nxt.ps = 1'b0;
            s_nxt.ctl.wake_start = active;
         end
      end
      else if (s_r.misc[led_pwm_pkg::MISC_PS_BIT] && !active && (idle_long || eng_gap_ahead_in))
         s_nxt.ps = 1'b1;

      // pump gain
      unique case (pump_mode_sel)
         led_pwm_pkg::MODE_OFF:
            s_nxt.ctl.gain = led_pwm_pkg::GAIN_OFF;
         led_pwm_pkg::MODE_BYPASS:
            s_nxt.ctl.gain = led_pwm_pkg::GAIN_1X;
         led_pwm_pkg::MODE_BOOST:
            s_nxt.ctl.gain = led_pwm_pkg::GAIN_1P5X;
         led_pwm_pkg::MODE_AUTO:
         begin
            if (idle_long || s_r.ctl.gain == led_pwm_pkg::GAIN_OFF || s_r.ctl.gain == led_pwm_pkg::GAIN_WEAK)
               s_nxt.ctl.gain = led_pwm_pkg::GAIN_1X;
            else if (gain_up)
               s_nxt.ctl.gain = led_pwm_pkg::GAIN_1P5X;
            else if (gain_down)
               s_nxt.ctl.gain = led_pwm_pkg::GAIN_1X;
         end
      endcase
      if (s_nxt.ps && pump_mode_sel != led_pwm_pkg::MODE_OFF)
         s_nxt.ctl.gain = led_pwm_pkg::GAIN_WEAK;
      s_nxt.ctl.discharge   = s_nxt.ctl.gain == led_pwm_pkg::GAIN_OFF;
      s_nxt.ctl.drivers_off = s_nxt.ps;
      // with the internal clock the controller itself must keep running
      s_nxt.ctl.analog_off  = (s_nxt.ps && !s_r.misc[led_pwm_pkg::MISC_INTCLK_BIT])
                            || (pwm_offtime_sleep_enable && !s_nxt.ps && !(|s_nxt.led_on));
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         s_r               <= '0;
         s_r.hyst          <= HYST_DEF;
         s_r.ctl.discharge <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign reg_rdata_out   = s_r.rdata;
   assign led_pwm_out     = s_r.led_on;
   assign led_current_out = s_r.cur;
   assign power_ctrl_out  = s_r.ctl;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence s_auto_free;
      pump_mode_sel == led_pwm_pkg::MODE_AUTO && !idle_long && !s_nxt.ps;
   endsequence

   property p_pump_off;
      pump_mode_sel == led_pwm_pkg::MODE_OFF |=>
         power_ctrl_out.gain == led_pwm_pkg::GAIN_OFF && power_ctrl_out.discharge;
   endproperty
   a_pump_off: assert property (p_pump_off)
      else $error("pump not off in mode off");

   property p_boost;
      pump_mode_sel == led_pwm_pkg::MODE_BOOST && !s_nxt.ps |=> power_ctrl_out.gain == led_pwm_pkg::GAIN_1P5X;
   endproperty
   a_boost: assert property (p_boost)
      else $error("forced boost not applied");

   property p_auto_up;
      s_auto_free and (gain_up && power_ctrl_out.gain == led_pwm_pkg::GAIN_1X) |=>
         power_ctrl_out.gain == led_pwm_pkg::GAIN_1P5X;
   endproperty
   a_auto_up: assert property (p_auto_up)
      else $error("gain not raised on saturation");

   property p_filter;
      $rose(power_ctrl_out.gain == led_pwm_pkg::GAIN_1P5X) && pump_mode_sel == led_pwm_pkg::MODE_AUTO |->
         $past(gain_up);
   endproperty
   a_filter: assert property (p_filter)
      else $error("gain raised before filter expired");

   property p_hyst;
      s_auto_free and (!gain_down && power_ctrl_out.gain == led_pwm_pkg::GAIN_1P5X) |=>
         power_ctrl_out.gain == led_pwm_pkg::GAIN_1P5X;
   endproperty
   a_hyst: assert property (p_hyst)
      else $error("gain dropped inside hysteresis");

   property p_idle_1x;
      pump_mode_sel == led_pwm_pkg::MODE_AUTO && idle_long && !s_nxt.ps |=>
         power_ctrl_out.gain == led_pwm_pkg::GAIN_1X;
   endproperty
   a_idle_1x: assert property (p_idle_1x)
      else $error("idle outputs did not give 1x");

   property p_ps_en;
      !s_r.misc[led_pwm_pkg::MISC_PS_BIT] |=> !power_ctrl_out.drivers_off;
   endproperty
   a_ps_en: assert property (p_ps_en)
      else $error("power save without enable");

   property p_wake;
      s_r.ps && active |=> !power_ctrl_out.drivers_off && power_ctrl_out.wake_start ##1 !power_ctrl_out.wake_start;
   endproperty
   a_wake: assert property (p_wake)
      else $error("no wakeup on pwm demand");

   property p_offtime;
      power_ctrl_out.analog_off && !power_ctrl_out.drivers_off |->
         led_pwm_out == '0 && $past(pwm_offtime_sleep_enable);
   endproperty
   a_offtime: assert property (p_offtime)
      else $error("analogue off during pwm on time");

endmodule

// ==== tb/pump_model.sv ====
`timescale 1ns/1ps
module pump_model (
   // clock and controls from the block
   input  wire logic                    ref_clk_in,
   input  wire led_pwm_pkg::pump_gain_e gain_in,
   input  wire logic [8:0]              led_pwm_in,
   // scenario control: battery too weak for the boosted leds
   input  wire logic                    batt_low_in,
   // monitor outputs
   output logic [5:0]                   boost_sat_out,
   output logic                         batt_ok_out
);
   logic [4:0] hold_r = 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // pwm off gaps are short, so headroom loss is held across them
   always_ff @(posedge ref_clk_in)
      hold_r <= (|led_pwm_in[5:0]) ? 5'h10 : hold_r - ((hold_r != 5'h00) ? 5'h01 : 5'h00);
   // only the boosted outputs see the pump, and 1.5x restores their headroom
   assign boost_sat_out = {6{batt_low_in && hold_r != 5'h00 && gain_in != led_pwm_pkg::GAIN_1P5X}};
   assign batt_ok_out   = !batt_low_in;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [8:0] eng_own = 9'h000;
   logic [8:0][7:0] eng_duty = '0;
   logic [5:0] boost_sat;
   logic batt_ok;
   logic batt_low = 1'b0;
   logic eng_gap = 1'b0;
   logic [8:0] led_pwm;
   logic [8:0][7:0] led_cur;
   led_pwm_pkg::power_ctrl_s pctl;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   int wakes = 0;
   int off_cnt = 0;
   int gap_n = 0;
   int on_cnt [9];
   int exp_on [9] = '{8190, 2056, 8064, 4112, 0, 8190, 0, 0, 0};

   always #2.5 ref_clk_in = ~ref_clk_in;

   led_pwm_pump_ctrl #(.PWM_STEP_CYC(2), .IDLE_CYC(200)) u_dut (
      .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .reg_wr_in(reg_wr), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .eng_own_in(eng_own), .eng_duty_in(eng_duty),
      .eng_gap_ahead_in(eng_gap), .boost_sat_in(boost_sat), .batt_ok_in(batt_ok), .led_pwm_out(led_pwm),
      .led_current_out(led_cur), .power_ctrl_out(pctl));

   pump_model u_pump (
      .ref_clk_in(ref_clk_in), .gain_in(pctl.gain), .led_pwm_in(led_pwm), .batt_low_in(batt_low),
      .boost_sat_out(boost_sat), .batt_ok_out(batt_ok));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (pctl.wake_start === 1'b1)
         wakes++;
      // the whole run needs about 66k cycles
      if (cyc == 90000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge ref_clk_in);
      reg_addr <= a;
      @(posedge ref_clk_in);
      #1 chk(name, {8'h00, exp}, {8'h00, reg_rdata});
   endtask

   // gain must arrive no earlier than lo and before hi cycles
   task automatic wait_gain(input led_pwm_pkg::pump_gain_e g, input int lo, input int hi, input string name);
      int n;
      n = 0;
      while (pctl.gain !== g && n < hi)
      begin
         @(posedge ref_clk_in);
         n++;
      end
      chk(name, 16'h0001, {15'h0000, (n >= lo && n < hi)});
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      #1 chk("discharge", 16'h0001, {15'h0000, pctl.discharge});
      chk("gain", 16'h0000, {14'h0000, pctl.gain});
      rd(led_pwm_pkg::HYST_OFS, 8'h10, "hyst");
      rd(led_pwm_pkg::PWM_OFS, 8'h00, "pwm0");
      wr(8'hF0, 8'h55);
      rd(8'hF0, 8'h00, "unmapped");
      for (int i = 0; i < 9; i++)
         wr(led_pwm_pkg::CUR_OFS + 8'(i), 8'h10 + 8'(i));
      wr(led_pwm_pkg::CUR_OFS + 8'h08, 8'hFF);
      // the last write lands at the edge the task returns on
      #1;
      for (int i = 0; i < 8; i++)
         chk("current", {8'h00, 8'h10 + 8'(i)}, {8'h00, led_cur[i]});
      chk("current8", 16'h00FF, {8'h00, led_cur[8]});
      rd(led_pwm_pkg::CUR_OFS + 8'h08, 8'hFF, "current8 read");
      done("reset and registers");

      wr(led_pwm_pkg::MISC_OFS, 8'h08);
      wait_gain(led_pwm_pkg::GAIN_1X, 0, 4, "bypass");
      chk("discharge bypass", 16'h0000, {15'h0000, pctl.discharge});
      wr(led_pwm_pkg::MISC_OFS, 8'h10);
      wait_gain(led_pwm_pkg::GAIN_1P5X, 0, 4, "boost");
      wr(led_pwm_pkg::MISC_OFS, 8'h00);
      wait_gain(led_pwm_pkg::GAIN_OFF, 0, 4, "off");
      #1 chk("discharge off", 16'h0001, {15'h0000, pctl.discharge});
      done("pump modes");

      // ch1 engine owned, ch2 log, ch5 full fader, ch6 zero fader
      for (int i = 0; i < 7; i++)
         wr(led_pwm_pkg::PWM_OFS + 8'(i), (i == 3) ? 8'h80 : (i == 4) ? 8'h00 : 8'hFF);
      wr(led_pwm_pkg::CTRL_OFS + 8'h02, 8'h20);
      wr(led_pwm_pkg::CTRL_OFS + 8'h05, 8'h01);
      wr(led_pwm_pkg::CTRL_OFS + 8'h06, 8'h02);
      wr(led_pwm_pkg::FADER_OFS, 8'hFF);
      wr(led_pwm_pkg::FADER_OFS + 8'h01, 8'h00);
      eng_own <= 9'h002;
      eng_duty[1] <= 8'h40;
      repeat (9000) @(posedge ref_clk_in);
      while (led_pwm[0] !== 1'b1 && cyc < 40000)
         @(posedge ref_clk_in);
      on_cnt = '{default: 0};
      off_cnt = 0;
      for (int k = 0; k < 8192; k++)
      begin
         for (int i = 0; i < 9; i++)
            on_cnt[i] += (led_pwm[i] === 1'b1);
         off_cnt += (pctl.analog_off === 1'b1);
         @(posedge ref_clk_in);
      end
      for (int i = 0; i < 9; i++)
         chk("pwm on cycles", exp_on[i][15:0], on_cnt[i][15:0]);
      chk("no offtime save", 16'h0000, off_cnt[15:0]);
      done("pwm");

      wr(led_pwm_pkg::HYST_OFS, 8'h01);
      wr(led_pwm_pkg::MISC_OFS, 8'h19);
      wait_gain(led_pwm_pkg::GAIN_1X, 0, 4, "auto start");
      batt_low <= 1'b1;
      repeat (100) @(posedge ref_clk_in);
      // an unfiltered monitor would already have raised the gain here
      chk("glitch gain", 16'h0001, {14'h0000, pctl.gain});
      batt_low <= 1'b0;
      repeat (4200) @(posedge ref_clk_in);
      chk("glitch settle", 16'h0001, {14'h0000, pctl.gain});
      batt_low <= 1'b1;
      wait_gain(led_pwm_pkg::GAIN_1P5X, 3900, 4100, "sat up");
      batt_low <= 1'b0;
      wait_gain(led_pwm_pkg::GAIN_1X, 200, 300, "batt down");
      done("auto gain");

      batt_low <= 1'b1;
      wait_gain(led_pwm_pkg::GAIN_1P5X, 0, 4100, "sat again");
      eng_own <= 9'h000;
      for (int i = 0; i < 9; i++)
         wr(led_pwm_pkg::PWM_OFS + 8'(i), 8'h00);
      wait_gain(led_pwm_pkg::GAIN_1X, 0, 8700, "idle 1x");
      batt_low <= 1'b0;
      wr(led_pwm_pkg::MISC_OFS, 8'h39);
      wait_gain(led_pwm_pkg::GAIN_WEAK, 0, 8700, "weak");
      #1 chk("drivers off", 16'h0001, {15'h0000, pctl.drivers_off});
      chk("analog on", 16'h0000, {15'h0000, pctl.analog_off});
      wakes = 0;
      wr(led_pwm_pkg::PWM_OFS, 8'hFF);
      while (pctl.drivers_off !== 1'b0 && cyc < 80000)
         @(posedge ref_clk_in);
      repeat (2) @(posedge ref_clk_in);
      chk("wake pulses", 16'h0001, wakes[15:0]);
      chk("wake gain", 16'h0001, {14'h0000, pctl.gain});
      done("power save");

      // look-ahead gap enters power save long before the idle timer
      eng_gap <= 1'b1;
      wr(led_pwm_pkg::PWM_OFS, 8'h00);
      gap_n = 0;
      while (pctl.drivers_off !== 1'b1 && gap_n < 300)
      begin
         @(posedge ref_clk_in);
         gap_n = (led_pwm[0] === 1'b1) ? 0 : gap_n + 1;
      end
      chk("gap entry", 16'h0001, {15'h0000, (gap_n < 8)});
      eng_gap <= 1'b0;
      wr(led_pwm_pkg::MISC_OFS, 8'h38);
      @(posedge ref_clk_in);
      #1 chk("analog off ext", 16'h0001, {15'h0000, pctl.analog_off});
      rd(led_pwm_pkg::STAT_OFS, 8'h17, "status");
      done("look-ahead and clock");

      // off-time save with temperature compensation halving the duty
      wr(led_pwm_pkg::MISC_OFS, 8'h5C);
      wr(led_pwm_pkg::PWM_OFS, 8'h80);
      repeat (8300) @(posedge ref_clk_in);
      on_cnt[0] = 0;
      off_cnt = 0;
      for (int k = 0; k < 8192; k++)
      begin
         on_cnt[0] += (led_pwm[0] === 1'b1);
         off_cnt += (pctl.analog_off === 1'b1);
         @(posedge ref_clk_in);
      end
      chk("tc on cycles", 16'h0808, on_cnt[0][15:0]);
      chk("offtime cycles", 16'h17F8, off_cnt[15:0]);
      done("offtime and compensation");
      end_sim();
   end
endmodule
